// ==== verilog/fast_ethernet_4b5b_mlt3_coder.sv ====
// 100 Mb/s 4b/5b transmit encoder, line coder and receive decoder
`default_nettype none

module fast_ethernet_4b5b_mlt3_coder (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // configuration
    input  wire logic       encode_enable,
    // transmit nibbles from the mac
    input  wire logic       tx_en,
    input  wire logic       tx_er,
    input  wire logic [3:0] txd,
    output logic            tx_nibble_take,
    // transmit line
    output logic            tx_bit_strobe,
    output logic            tx_nrzi,
    output logic            tx_mlt3_pos,
    output logic            tx_mlt3_neg,
    // descrambled receive bits
    input  wire logic       rx_bit,
    input  wire logic       rx_bit_valid,
    // receive nibbles to the mac
    output logic            rx_nibble_strobe,
    output logic [3:0]      rxd,
    output logic            rx_dv,
    output logic            rx_crs,
    output logic            rx_er
);

    ////////////////////////////////////////////////////////////////////////////
    // state types
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SEND_K,
        TX_DATA,
        TX_SEND_R
    } tx_phase_t;

    typedef enum logic [1:0] {
        RX_HUNT,
        RX_FRAME,
        RX_AFTER_T
    } rx_phase_t;

    typedef struct packed {
        tx_phase_t   tx_phase;
        logic [4:0]  tx_sym;
        logic        nib_take;
        rx_phase_t   rx_phase;
        logic [14:0] hist;
        logic [2:0]  bit_cnt;
        logic        prev_idle;
        logic        pend_k;
        logic        strobe;
        logic [3:0]  rxd;
        logic        dv;
        logic        crs;
        logic        er;
    } coder_state_t;

    coder_state_t st;
    coder_state_t next_st;
    logic         sym_take;

    ////////////////////////////////////////////////////////////////////////////
    // line side of the transmitter
    tx_line_serializer u_line (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .sym        (st.tx_sym),
        .sym_take   (sym_take),
        .bit_strobe (tx_bit_strobe),
        .nrzi       (tx_nrzi),
        .mlt3_pos   (tx_mlt3_pos),
        .mlt3_neg   (tx_mlt3_neg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [14:0] hist;
        logic [4:0]  sym;
        logic [4:0]  dec;
        hist    = {st.hist[13:0], rx_bit};
        sym     = hist[4:0];
        dec     = coder_pkg::decode_group(hist[4:0]);
        next_st = st;
        next_st.nib_take = 1'b0;
        next_st.strobe   = 1'b0;
        next_st.er       = 1'b0;

        // transmit: pick the symbol that follows the one just taken
        if (sym_take) begin
            unique case (st.tx_phase)
                TX_IDLE: begin
                    if (tx_en) begin
                        next_st.tx_sym   = coder_pkg::CG_J;
                        next_st.tx_phase = TX_SEND_K;
                        next_st.nib_take = 1'b1;
                    end else begin
                        next_st.tx_sym   = coder_pkg::CG_IDLE;
                    end
                end
                TX_SEND_K: begin
                    next_st.tx_sym   = coder_pkg::CG_K;
                    next_st.tx_phase = TX_DATA;
                    next_st.nib_take = 1'b1;
                end
                TX_DATA: begin
                    if (!tx_en) begin
                        next_st.tx_sym   = coder_pkg::CG_T;
                        next_st.tx_phase = TX_SEND_R;
                    end else if (!encode_enable) begin
                        next_st.tx_sym   = {txd, tx_er};
                        next_st.nib_take = 1'b1;
                    end else if (tx_er) begin
                        next_st.tx_sym   = coder_pkg::CG_H;
                        next_st.nib_take = 1'b1;
                    end else begin
                        next_st.tx_sym   = coder_pkg::encode_nibble(txd);
                        next_st.nib_take = 1'b1;
                    end
                end
                TX_SEND_R: begin
                    next_st.tx_sym   = coder_pkg::CG_R;
                    next_st.tx_phase = TX_IDLE;
                end
            endcase
        end

        // receive: second nibble of the start pair
        if (st.pend_k) begin
            next_st.pend_k = 1'b0;
            next_st.strobe = 1'b1;
            next_st.rxd    = coder_pkg::SSD_NIB;
        end

        if (rx_bit_valid) begin
            next_st.hist = hist;
            unique case (st.rx_phase)
                RX_HUNT: begin
                    // alignment from the start pair
                    if (hist[9:0] == coder_pkg::SSD_PAIR) begin
                        if (hist[14:10] == coder_pkg::CG_IDLE) begin
                            next_st.rx_phase  = RX_FRAME;
                            next_st.bit_cnt   = 3'h0;
                            next_st.prev_idle = 1'b0;
                            next_st.dv        = 1'b1;
                            next_st.crs       = 1'b1;
                            next_st.strobe    = 1'b1;
                            next_st.rxd       = coder_pkg::SSD_NIB;
                            next_st.pend_k    = 1'b1;
                        end else begin
                            next_st.er     = 1'b1;
                            next_st.strobe = 1'b1;
                        end
                    end
                end
                RX_FRAME, RX_AFTER_T: begin
                    if (st.bit_cnt != coder_pkg::SYM_LAST_BIT) begin
                        next_st.bit_cnt = 3'(st.bit_cnt + 3'h1);
                    end else begin
                        next_st.bit_cnt   = 3'h0;
                        next_st.strobe    = 1'b1;
                        next_st.prev_idle = (sym == coder_pkg::CG_IDLE);
                        if (st.rx_phase == RX_AFTER_T && sym == coder_pkg::CG_R) begin
                            next_st.rx_phase = RX_HUNT;
                            next_st.dv       = 1'b0;
                            next_st.crs      = 1'b0;
                            next_st.strobe   = 1'b0;
                        end else if (st.rx_phase == RX_AFTER_T) begin
                            next_st.rx_phase = RX_FRAME;
                            next_st.er       = 1'b1;
                        end else if (sym == coder_pkg::CG_T) begin
                            next_st.rx_phase = RX_AFTER_T;
                            next_st.strobe   = 1'b0;
                        end else if (sym == coder_pkg::CG_R) begin
                            next_st.er = 1'b1;
                        end else if (sym == coder_pkg::CG_J) begin
                            next_st.er = 1'b1;
                        end else if (sym == coder_pkg::CG_K) begin
                            next_st.er = 1'b1;
                        end else if (sym == coder_pkg::CG_IDLE) begin
                            next_st.strobe = 1'b0;
                            if (st.prev_idle) begin
                                next_st.rx_phase = RX_HUNT;
                                next_st.dv       = 1'b0;
                                next_st.crs      = 1'b0;
                            end
                        end else if (dec[4]) begin
                            next_st.rxd = dec[3:0];
                        end else begin
                            // invalid or transmit error symbol
                            next_st.er = coder_pkg::is_invalid(sym) | (sym == coder_pkg::CG_H);
                        end
                    end
                end
                default: begin
                    next_st.rx_phase = RX_HUNT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st          <= '0;
            st.tx_phase <= TX_IDLE;
            st.tx_sym   <= coder_pkg::CG_IDLE;
            st.rx_phase <= RX_HUNT;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign tx_nibble_take   = st.nib_take;
    assign rx_nibble_strobe = st.strobe;
    assign rxd              = st.rxd;
    assign rx_dv            = st.dv;
    assign rx_crs           = st.crs;
    assign rx_er            = st.er;

endmodule

`default_nettype wire

// ==== shared/coder_pkg.sv ====
// constants, code tables and helpers shared by the 100 Mb/s coder
`default_nettype none

package coder_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // control code-groups, leftmost bit sent first
    localparam logic [4:0] CG_IDLE  = 5'h1f;
    localparam logic [4:0] CG_J     = 5'h18;
    localparam logic [4:0] CG_K     = 5'h11;
    localparam logic [4:0] CG_T     = 5'h0d;
    localparam logic [4:0] CG_R     = 5'h07;
    localparam logic [4:0] CG_H     = 5'h04;
    localparam logic [3:0] SSD_NIB  = 4'h5;
    localparam logic [9:0] SSD_PAIR = {CG_J, CG_K};
    localparam logic [9:0] ESD_PAIR = {CG_T, CG_R};

    // data code-groups indexed by nibble
    localparam logic [4:0] DATA_CG [16] = '{
        5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
    };

    ////////////////////////////////////////////////////////////////////////////
    // line rate from the 200 MHz reference
    localparam int          REF_CLK_MHZ   = 200;
    localparam int          LINE_RATE_MHZ = 125;
    localparam logic [7:0]  RATE_STEP     = 8'(LINE_RATE_MHZ);
    localparam logic [7:0]  RATE_WRAP     = 8'(REF_CLK_MHZ);
    localparam logic [2:0]  SYM_LAST_BIT  = 3'h4;

    // scrambler: key = s[n-11] ^ s[n-9]
    localparam logic [10:0] SCR_SEED      = 11'h7ff;
    localparam int          SCR_TAP_A     = 10;
    localparam int          SCR_TAP_B     = 8;

    // three-level line phases: zero, plus, zero, minus
    localparam logic [1:0]  MLT_PLUS      = 2'h1;
    localparam logic [1:0]  MLT_MINUS     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // nibble to data code-group
    function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
        encode_nibble = DATA_CG[nib];
    endfunction

    // code-group to {is_data, nibble}
    function automatic logic [4:0] decode_group(input logic [4:0] cg);
        decode_group = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (cg == DATA_CG[i]) begin
                decode_group = {1'b1, 4'(i)};
            end
        end
    endfunction

    // code-groups with no meaning at all
    function automatic logic is_invalid(input logic [4:0] cg);
        case (cg)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
            5'h06, 5'h08, 5'h0c, 5'h10, 5'h19: is_invalid = 1'b1;
            default:                           is_invalid = 1'b0;
        endcase
    endfunction

endpackage

`default_nettype wire

// ==== verilog/tx_line_serializer.sv ====
// scrambler, serializer, nrzi and three-level line coder
`default_nettype none

module tx_line_serializer (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // symbol from the encoder
    input  wire logic [4:0] sym,
    output logic            sym_take,
    // line side
    output logic            bit_strobe,
    output logic            nrzi,
    output logic            mlt3_pos,
    output logic            mlt3_neg
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]  acc;
        logic [4:0]  shreg;
        logic [2:0]  cnt;
        logic [10:0] lfsr;
        logic [1:0]  phase;
        logic        take;
        logic        strobe;
        logic        nrzi;
        logic        pos;
        logic        neg;
    } ser_state_t;

    ser_state_t st;
    ser_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [8:0] sum;
        logic       plain;
        logic       key;
        logic       line;
        logic [1:0] ph;
        sum     = 9'h000;
        plain   = 1'b0;
        key     = 1'b0;
        line    = 1'b0;
        ph      = st.phase;
        next_st = st;
        next_st.take   = 1'b0;
        next_st.strobe = 1'b0;
        // 125 MHz bit tick out of the 200 MHz clock
        sum = {1'b0, st.acc} + {1'b0, coder_pkg::RATE_STEP};
        if (sum >= {1'b0, coder_pkg::RATE_WRAP}) begin
            next_st.acc = 8'(sum - {1'b0, coder_pkg::RATE_WRAP});
            // parallel in, serial out
            if (st.cnt == 3'h0) begin
                plain         = sym[4];
                next_st.shreg = {sym[3:0], 1'b0};
                next_st.cnt   = coder_pkg::SYM_LAST_BIT;
                next_st.take  = 1'b1;
            end else begin
                plain         = st.shreg[4];
                next_st.shreg = {st.shreg[3:0], 1'b0};
                next_st.cnt   = 3'(st.cnt - 3'h1);
            end
            // eleven-bit scrambler key
            key  = st.lfsr[coder_pkg::SCR_TAP_A] ^ st.lfsr[coder_pkg::SCR_TAP_B];
            next_st.lfsr = {st.lfsr[9:0], key};
            line = plain ^ key;
            // nrzi: a one toggles the line
            next_st.nrzi = st.nrzi ^ line;
            // three-level: a one steps to the next level
            if (line) begin
                ph = 2'(st.phase + 2'h1);
            end
            next_st.phase  = ph;
            next_st.pos    = (ph == coder_pkg::MLT_PLUS);
            next_st.neg    = (ph == coder_pkg::MLT_MINUS);
            next_st.strobe = 1'b1;
        end else begin
            next_st.acc = sum[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st      <= '0;
            st.lfsr <= coder_pkg::SCR_SEED;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign sym_take   = st.take;
    assign bit_strobe = st.strobe;
    assign nrzi       = st.nrzi;
    assign mlt3_pos   = st.pos;
    assign mlt3_neg   = st.neg;

endmodule

`default_nettype wire

// ==== tb/coder_checker.sv ====
// port assertions for the 100 Mb/s coder
`default_nettype none

module coder_checker (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       srst,
    // transmit side
    input wire logic       tx_en,
    input wire logic       tx_nibble_take,
    input wire logic       tx_bit_strobe,
    input wire logic       tx_nrzi,
    input wire logic       tx_mlt3_pos,
    input wire logic       tx_mlt3_neg,
    // receive side
    input wire logic       rx_nibble_strobe,
    input wire logic [3:0] rxd,
    input wire logic       rx_dv,
    input wire logic       rx_crs,
    input wire logic       rx_er
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////
    a_mlt_exclusive: assert property (!(tx_mlt3_pos && tx_mlt3_neg))
        else $error("line at both levels");
    a_mlt_no_jump: assert property ($rose(tx_mlt3_neg) |-> !$past(tx_mlt3_pos))
        else $error("line jumped plus to minus");
    a_line_hold: assert property (!tx_bit_strobe |->
        $stable({tx_nrzi, tx_mlt3_pos, tx_mlt3_neg}))
        else $error("line moved without strobe");
    a_mlt_follows_nrzi: assert property (tx_bit_strobe |-> ((tx_nrzi != $past(tx_nrzi))
        == ({tx_mlt3_pos, tx_mlt3_neg} != $past({tx_mlt3_pos, tx_mlt3_neg}))))
        else $error("level step disagrees with nrzi");
    a_bit_rate: assert property (!tx_bit_strobe && !$past(srst) |=> tx_bit_strobe)
        else $error("line bit gap too long");
    a_take_pulse: assert property (tx_nibble_take |=> !tx_nibble_take)
        else $error("take longer than one cycle");
    a_take_needs_en: assert property (tx_nibble_take |-> $past(tx_en))
        else $error("nibble taken while idle");
    a_er_strobed: assert property (rx_er |-> rx_nibble_strobe)
        else $error("receive error without strobe");
    a_crs_dv: assert property (rx_crs == rx_dv)
        else $error("carrier and valid differ");
    a_ssd_nibbles: assert property ($rose(rx_dv) |-> rx_nibble_strobe && rxd == 4'h5
        ##1 rx_nibble_strobe && rxd == 4'h5)
        else $error("start pair not 5 5");

    c_frame_start: cover property ($rose(rx_dv));
    c_frame_error: cover property (rx_er && rx_dv);
    c_frame_end: cover property ($fell(rx_dv));
    c_nibble_take: cover property (tx_nibble_take);
endmodule

bind fast_ethernet_4b5b_mlt3_coder coder_checker u_chk (.ref_clk, .srst, .tx_en,
    .tx_nibble_take, .tx_bit_strobe, .tx_nrzi, .tx_mlt3_pos, .tx_mlt3_neg,
    .rx_nibble_strobe, .rxd, .rx_dv, .rx_crs, .rx_er);

`default_nettype wire

// ==== tb/mac_model.sv ====
// mac-side nibble source for the transmit path
`default_nettype none

module mac_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // frame request
    input  wire logic        go,
    input  wire logic [63:0] nibs,
    input  wire logic [15:0] ers,
    // mii transmit side
    input  wire logic        tx_nibble_take,
    output logic             tx_en,
    output logic             tx_er,
    output logic [3:0]       txd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] idx;

    // nibble held until the coder takes it
    always_ff @(posedge ref_clk) begin
        if (srst || go) begin
            tx_en <= go;
            idx <= 4'h0;
        end else if (tx_en && tx_nibble_take) begin
            tx_en <= (idx != 4'hf);
            idx <= idx + 4'h1;
        end
    end
    assign txd = nibs[idx*4 +: 4];
    assign tx_er = tx_en & ers[idx];
endmodule

`default_nettype wire

// ==== tb/tb_fast_ethernet_4b5b_mlt3_coder.sv ====
// self-checking bench for the 100 Mb/s coder
`default_nettype none

module tb_fast_ethernet_4b5b_mlt3_coder;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        encode_enable;
    logic        go;
    logic [63:0] nibs;
    logic [15:0] ers;
    logic        rx_bit;
    logic        rx_bit_valid;
    logic        tx_en, tx_er, tx_nibble_take, tx_bit_strobe, tx_nrzi, tx_mlt3_pos;
    logic        tx_mlt3_neg, rx_nibble_strobe, rx_dv, rx_crs, rx_er, pn, lk, kb;
    logic [3:0]  txd, rxd;
    logic [4:0]  te;
    logic [5:0]  re;
    logic [10:0] lfsr;
    logic [9:0]  win;
    integer      seed = 32'h471c;
    int          err_total = 0;
    int          checked = 0;
    int          cnt;
    logic [4:0]  txq [$];
    logic [5:0]  rxq [$];
    logic [4:0]  cg_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic [4:0]  bad_tab [15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c,
                                 5'h10, 5'h19, 5'h04, 5'h07, 5'h18, 5'h11, 5'h0d};

    fast_ethernet_4b5b_mlt3_coder dut (.ref_clk, .srst, .encode_enable, .tx_en, .tx_er, .txd,
        .tx_nibble_take, .tx_bit_strobe, .tx_nrzi, .tx_mlt3_pos, .tx_mlt3_neg, .rx_bit,
        .rx_bit_valid, .rx_nibble_strobe, .rxd, .rx_dv, .rx_crs, .rx_er);
    mac_model u_mac (.ref_clk, .srst, .go, .nibs, .ers, .tx_nibble_take, .tx_en, .tx_er,
        .txd);

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [4:0] e, input logic [4:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic tx_frame(input logic enc, input logic [63:0] n, input logic [15:0] e);
        int w;
        w = 0;
        @(posedge ref_clk);
        encode_enable <= enc;
        nibs <= n;
        ers <= e;
        go <= 1'b1;
        for (int i = 2; i < 16; i++) begin
            if (!enc) txq.push_back({n[i*4 +: 4], e[i]});
            else txq.push_back(e[i] ? 5'h04 : cg_tab[n[i*4 +: 4]]);
        end
        txq.push_back(5'h0d);
        txq.push_back(5'h07);
        txq.push_back(5'h1f);
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge ref_clk);
        while (tx_en === 1'b1 && w < 400) begin
            @(posedge ref_clk);
            w++;
        end
        repeat (64) @(posedge ref_clk);
        cmp("tx left", 5'h00, 5'(txq.size()));
    endtask

    task automatic send_cg(input logic [4:0] cg);
        for (int i = 4; i >= 0; i--) begin
            @(posedge ref_clk);
            rx_bit <= cg[i];
            rx_bit_valid <= 1'b1;
        end
    endtask

    task automatic rx_frame(input logic [4:0] bad, input logic is_bad);
        logic [3:0] nb;
        repeat (3) send_cg(5'h1f);
        send_cg(5'h18);
        send_cg(5'h11);
        rxq.push_back(6'h25);
        rxq.push_back(6'h25);
        repeat (3) begin
            nb = 4'($random(seed));
            send_cg(cg_tab[nb]);
            rxq.push_back({2'b10, nb});
        end
        if (is_bad) begin
            send_cg(bad);
            rxq.push_back(6'h10);
        end else begin
            send_cg(5'h0d);
            send_cg(5'h07);
        end
        repeat (3) send_cg(5'h1f);
        @(posedge ref_clk);
        rx_bit_valid <= 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp("rx_dv", 5'h00, {4'h0, rx_dv});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // descramble the line and compare each aligned group
    always @(negedge ref_clk) begin
        if (srst) begin
            lfsr = 11'h7ff;
            pn = 1'b0;
            lk = 1'b0;
            win = '0;
        end else if (tx_bit_strobe) begin
            kb = lfsr[10] ^ lfsr[8];
            win = {win[8:0], tx_nrzi ^ pn ^ kb};
            pn = tx_nrzi;
            lfsr = {lfsr[9:0], kb};
            if (!lk && win == 10'h311) begin
                lk = 1'b1;
                cnt = 0;
            end else if (lk) begin
                cnt++;
                if (cnt == 5) begin
                    cnt = 0;
                    te = (txq.size() > 0) ? txq.pop_front() : 5'h00;
                    cmp("tx group", te, win[4:0]);
                    lk = (txq.size() > 0);
                end
            end
        end
    end

    // receive results against the oldest note
    always @(negedge ref_clk) begin
        if (!srst && rx_nibble_strobe === 1'b1) begin
            if (rxq.size() == 0) begin
                cmp("rx strobe", 5'h00, 5'h01);
            end else begin
                re = rxq.pop_front();
                cmp("rx_er", {4'h0, re[4]}, {4'h0, rx_er});
                if (re[5]) cmp("rxd", {1'b0, re[3:0]}, {1'b0, rxd});
            end
        end
    end

    // whole run needs about 2300 cycles
    initial begin
        #100us;
        err_total++;
        finish_test();
    end

    initial begin
        encode_enable <= 1'b1;
        go <= 1'b0;
        nibs <= '0;
        ers <= '0;
        rx_bit <= 1'b0;
        rx_bit_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        tx_frame(1'b1, 64'hdcba987654321000, 16'h0000);
        tx_frame(1'b1, {32'($random(seed)), 32'h0000fe00}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            tx_frame(k[0], {32'($random(seed)), 32'($random(seed))},
                16'($random(seed)) & 16'hfffc);
        end
        $display("tx tests done");
        send_cg(5'h19);
        // start pair not preceded by idle while hunting
        send_cg(5'h0a);
        send_cg(5'h18);
        send_cg(5'h11);
        rxq.push_back(6'h10);
        rx_frame(5'h00, 1'b0);
        rx_frame(5'h00, 1'b0);
        for (int k = 0; k < 15; k++) begin
            rx_frame(bad_tab[k], 1'b1);
        end
        $display("rx tests done");
        finish_test();
    end
endmodule

`default_nettype wire
